// ===== rtl/sdci_defines.svh
`ifndef SDCI_DEFINES_SVH
`define SDCI_DEFINES_SVH
// Register word indices; byte address is four times the index
`define SDCI_IDX_CTL 16'h3b00
`define SDCI_IDX_STAT 16'h3b08
`define SDCI_IDX_BLOCK_BYTE_LENGTH 16'h3b1c
`define SDCI_IDX_BLOCK_TOTAL_COUNT 16'h3b20
`define SDCI_IDX_TXLO 16'h3b2c
`define SDCI_IDX_TXHI 16'h3b2d
`define SDCI_IDX_CMD 16'h3b30
`define SDCI_IDX_KICK 16'h3b31
`define SDCI_IDX_ARGLO 16'h3b34
`define SDCI_IDX_ARGHI 16'h3b35
`define SDCI_IDX_RSP0 16'h3b38
`define SDCI_IDX_RSP1 16'h3b39
`define SDCI_IDX_RSP2 16'h3b3c
`define SDCI_IDX_RSP3 16'h3b3d
`define SDCI_IDX_RSP4 16'h3b40
`define SDCI_IDX_RSP5 16'h3b41
`define SDCI_IDX_RSP6 16'h3b44
`define SDCI_IDX_RSP7 16'h3b45
`define SDCI_IDX_CIDX 16'h3b50
// Command word fields
`define SDCI_B_CLR 15
`define SDCI_B_INIT 14
`define SDCI_B_DATA 13
`define SDCI_B_STRM 12
`define SDCI_B_WDIR 11
`define SDCI_B_RSPH 10
`define SDCI_B_RSPL 9
`define SDCI_B_BUSY 8
`define SDCI_B_PP 7
`define SDCI_CMD_MASK 16'hffbf
// Reset values
`define SDCI_BLOCK_BYTE_LENGTH_RST 12'h200
// Timing and frame counts
`define SDCI_REF_CLK_NS 4
`define SDCI_CARD_CLK_NS 64
`define SDCI_INIT_CLKS 80
`define SDCI_FRAME_LAST 8'd47
`define SDCI_CRC_START 8'd40
`define SDCI_RSP_SHORT_LAST 8'd47
`define SDCI_RSP_LONG_LAST 8'd135
`define SDCI_CIDX_BITS 8'd8
`define SDCI_CRC7_POLY 7'h09
`endif

// ===== rtl/sdci_pkg.sv
package sdci_pkg;
    typedef enum logic [2:0] {
        SDCI_IDLE, SDCI_INIT, SDCI_CMD, SDCI_RSP_WAIT, SDCI_RSP, SDCI_BUSY, SDCI_DATA
    } sdci_state_e;

    typedef struct packed {
        sdci_state_e st;
        logic [15:0] cmd_word;
        logic kick_arm;
        logic [15:0] arg_lo;
        logic [15:0] arg_hi;
        logic [15:0] tx_lo;
        logic [15:0] tx_hi;
        logic tx_full;
        logic endian_be;
        logic [11:0] block_byte_length;
        logic [15:0] block_total_count;
        logic rx_rdy;
        logic tx_rdy;
        logic [7:0] cidx;
        logic [127:0] rsp;
        logic [47:0] shift;
        logic [6:0] crc;
        logic [7:0] cnt;
        logic [7:0] div;
        logic card_clk;
        logic line;
        logic cmd_oe;
        logic dat_line;
        logic dat_oe;
        logic [15:0] dcnt;
        logic [15:0] blk_left;
        logic [31:0] dbuf;
        logic dma_req;
        logic a_wr;
        logic [15:0] a_idx;
        logic rd_ph;
        logic [31:0] hrdata;
        logic [1:0] cmd_sy;
        logic [1:0] dat_sy;
    } sdci_state_s;
endpackage

// ===== rtl/sdci_top.sv
`timescale 1ns/1ps
`include "sdci_defines.svh"

// Summary of operation
// - Writing the command word launches the command with the current argument.
// - Command word keeps its written value after the frame is loaded.
// - Command bit 15 clears receive-ready and transmit-ready status flags.
// - Command bit 14 inserts 80 card clocks before the command frame.
// - Command bit 13 says whether a data phase follows the command.
// - Bit 12 clear ends after blocks; set streams until a stop command.
// - Command bit 11 selects data direction: 0 read, 1 write.
// - Bits 10-9 choose response: none, 48 CRC, 136 CRC, 48 no CRC.
// - Command bit 8 makes the controller wait for card busy to end.
// - Command bit 7 selects push-pull, otherwise open-drain command drive.
// - Bits 5-0 give the sent command index; bit 6 reads zero.
// - Kick bit 0 raises one DMA request, later requests follow each transmit word taken on writes.
// - Transmit halves accept any writer; byte order follows endian control.
// - Response bits shift into the eight response words at bit 0, pushing old contents up.
// - Each response word holds 16 bits; first byte goes to index register.
// - Argument low half is bits 15-0, high half bits 31-16.
// - Block length holds 1 to FFFh bytes, resets to 200h.
// - Exact block count is moved; zero count runs until a stop command.
module sdci_top #(
    parameter int HALF_CYC = `SDCI_CARD_CLK_NS / (2 * `SDCI_REF_CLK_NS)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Card link
    output logic card_clk,
    output logic cmd_o,
    output logic cmd_oe,
    input wire logic cmd_i,
    output logic dat_o,
    output logic dat_oe,
    input wire logic dat_i,
    // DMA
    output logic dma_req
);
    import sdci_pkg::*;

    sdci_state_s s;
    sdci_state_s n;
    logic wr_cmd;
    logic rx_ev;
    logic tx_ev;
    logic launch;

    if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_chk
        $error("HALF_CYC out of range");
    end

    // One CRC7 step over a command bit
    function automatic logic [6:0] crc7_step(logic [6:0] c, logic b);
        logic fb;
        fb = c[6] ^ b;
        return {c[5:0], 1'b0} ^ (fb ? `SDCI_CRC7_POLY : 7'h00);
    endfunction

    // Where the controller goes after the command, response or busy stage
    function automatic sdci_state_e after_step(logic [15:0] w, logic [1:0] stage);
        if (stage == 2'd0 && w[`SDCI_B_RSPH:`SDCI_B_RSPL] != 2'b00) begin
            return SDCI_RSP_WAIT;
        end else if (stage != 2'd2 && w[`SDCI_B_BUSY]) begin
            return SDCI_BUSY;
        end else if (w[`SDCI_B_DATA]) begin
            return SDCI_DATA;
        end
        return SDCI_IDLE;
    endfunction

    // Register read mux; unmapped words read zero
    function automatic logic [31:0] rd_val(logic [15:0] idx, sdci_state_s r);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            `SDCI_IDX_CTL: v = {15'h0000, r.endian_be};
            `SDCI_IDX_STAT: v = {12'h000, r.st != SDCI_IDLE, r.tx_full, r.tx_rdy, r.rx_rdy};
            `SDCI_IDX_BLOCK_BYTE_LENGTH: v = {4'h0, r.block_byte_length};
            `SDCI_IDX_BLOCK_TOTAL_COUNT: v = r.block_total_count;
            `SDCI_IDX_TXLO: v = r.tx_lo;
            `SDCI_IDX_TXHI: v = r.tx_hi;
            `SDCI_IDX_CMD: v = r.cmd_word;
            `SDCI_IDX_KICK: v = {15'h0000, r.kick_arm};
            `SDCI_IDX_ARGLO: v = r.arg_lo;
            `SDCI_IDX_ARGHI: v = r.arg_hi;
            `SDCI_IDX_RSP0: v = r.rsp[15:0];
            `SDCI_IDX_RSP1: v = r.rsp[31:16];
            `SDCI_IDX_RSP2: v = r.rsp[47:32];
            `SDCI_IDX_RSP3: v = r.rsp[63:48];
            `SDCI_IDX_RSP4: v = r.rsp[79:64];
            `SDCI_IDX_RSP5: v = r.rsp[95:80];
            `SDCI_IDX_RSP6: v = r.rsp[111:96];
            `SDCI_IDX_RSP7: v = r.rsp[127:112];
            `SDCI_IDX_CIDX: v = {8'h00, r.cidx};
            default: v = 16'h0000;
        endcase
        return {16'h0000, v};
    endfunction

    assign wr_cmd = s.a_wr && s.a_idx == `SDCI_IDX_CMD;

    // Next-state logic for bus, command engine and data phase
    always_comb begin
        logic rise;
        logic fall;
        logic bitv;
        logic fin;
        logic [15:0] nxc;
        logic [15:0] lbits;
        logic [31:0] word;
        rise = 1'b0;
        fall = 1'b0;
        bitv = 1'b0;
        fin = 1'b0;
        nxc = 16'h0000;
        lbits = {1'b0, s.block_byte_length, 3'b000};
        word = 32'h0000_0000;
        launch = 1'b0;
        rx_ev = 1'b0;
        tx_ev = 1'b0;
        n = s;
        n.dma_req = 1'b0;
        n.cmd_sy = {s.cmd_sy[0], cmd_i};
        n.dat_sy = {s.dat_sy[0], dat_i};

        // Card clock runs only while a command is in flight
        if (s.st == SDCI_IDLE) begin
            n.div = 8'h00;
            n.card_clk = 1'b0;
        end else if (s.div == 8'(HALF_CYC - 1)) begin
            n.div = 8'h00;
            n.card_clk = ~s.card_clk;
            rise = ~s.card_clk;
            fall = s.card_clk;
        end else begin
            n.div = s.div + 8'h01;
        end

        // Reads take one wait state so a just-written value is seen
        if (s.rd_ph) begin
            n.hrdata = rd_val(s.a_idx, s);
            n.rd_ph = 1'b0;
        end
        n.a_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            n.a_idx = haddr[17:2];
            n.a_wr = hwrite;
            n.rd_ph = ~hwrite;
        end

        // Register writes in the data phase
        if (s.a_wr) begin
            case (s.a_idx)
                `SDCI_IDX_CTL: n.endian_be = hwdata[0];
                `SDCI_IDX_BLOCK_BYTE_LENGTH: n.block_byte_length = hwdata[11:0];
                `SDCI_IDX_BLOCK_TOTAL_COUNT: n.block_total_count = hwdata[15:0];
                `SDCI_IDX_TXLO: n.tx_lo = hwdata[15:0];
                `SDCI_IDX_TXHI: n.tx_hi = hwdata[15:0];
                `SDCI_IDX_ARGLO: n.arg_lo = hwdata[15:0];
                `SDCI_IDX_ARGHI: n.arg_hi = hwdata[15:0];
                `SDCI_IDX_KICK: begin
                    n.kick_arm = hwdata[0];
                    n.dma_req = hwdata[0];
                end
                `SDCI_IDX_CMD: begin
                    // launch, also the stop command; word kept until the next write
                    launch = 1'b1;
                    n.cmd_word = hwdata[15:0] & `SDCI_CMD_MASK;
                    if (hwdata[`SDCI_B_CLR]) begin
                        n.rx_rdy = 1'b0;
                        n.tx_rdy = 1'b0;
                    end
                    n.shift = {2'b01, hwdata[5:0], s.arg_hi, s.arg_lo, 8'h01};
                    n.crc = 7'h00;
                    n.cnt = 8'h00;
                    n.div = 8'h00;
                    n.card_clk = 1'b0;
                    n.blk_left = s.block_total_count;
                    n.dat_oe = 1'b0;
                    n.dat_line = 1'b1;
                    if (hwdata[`SDCI_B_INIT]) begin
                        n.st = SDCI_INIT;
                        n.line = 1'b1;
                        n.cmd_oe = hwdata[`SDCI_B_PP];
                    end else begin
                        n.st = SDCI_CMD;
                        n.line = 1'b0;
                        n.cmd_oe = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (!launch) begin
            case (s.st)
                SDCI_INIT: begin
                    // count card clocks on falling edges
                    if (fall && s.cnt == 8'(`SDCI_INIT_CLKS - 1)) begin
                        n.st = SDCI_CMD;
                        n.cnt = 8'h00;
                        n.line = 1'b0;
                        n.cmd_oe = 1'b1;
                    end else if (fall) begin
                        n.cnt = s.cnt + 8'h01;
                    end
                end
                SDCI_CMD: begin
                    if (fall) begin
                        // shift out MSB first, CRC over the first 40 bits
                        n.crc = (s.cnt < `SDCI_CRC_START) ? crc7_step(s.crc, s.shift[47]) : s.crc;
                        n.shift = {s.shift[46:0], 1'b0};
                        if (s.cnt == `SDCI_CRC_START - 8'd1) begin
                            n.shift[47:40] = {n.crc, 1'b1};
                        end
                        n.cnt = s.cnt + 8'h01;
                        n.line = n.shift[47];
                        // open drain drives only the low level
                        n.cmd_oe = s.cmd_word[`SDCI_B_PP] | ~n.shift[47];
                        if (s.cnt == `SDCI_FRAME_LAST) begin
                            n.line = 1'b1;
                            n.cmd_oe = 1'b0;
                            n.cnt = 8'h00;
                            // data phase or not; response or not
                            n.st = after_step(s.cmd_word, 2'd0);
                        end
                    end
                end
                SDCI_RSP_WAIT: begin
                    if (rise && !s.cmd_sy[1]) begin
                        n.st = SDCI_RSP;
                        n.cidx = {s.cidx[6:0], 1'b0};
                        n.cnt = 8'h01;
                    end
                end
                SDCI_RSP: begin
                    if (rise) begin
                        bitv = s.cmd_sy[1];
                        // first byte to index register; rest shifts into the response words
                        if (s.cnt < `SDCI_CIDX_BITS) begin
                            n.cidx = {s.cidx[6:0], bitv};
                        end else begin
                            n.rsp = {s.rsp[126:0], bitv};
                        end
                        n.cnt = s.cnt + 8'h01;
                        if (s.cnt == ((s.cmd_word[`SDCI_B_RSPH:`SDCI_B_RSPL] == 2'b10) ?
                                      `SDCI_RSP_LONG_LAST : `SDCI_RSP_SHORT_LAST)) begin
                            n.cnt = 8'h00;
                            n.st = after_step(s.cmd_word, 2'd1);
                        end
                    end
                end
                SDCI_BUSY: begin
                    // hold until the card releases data line
                    if (rise && s.dat_sy[1]) begin
                        n.st = after_step(s.cmd_word, 2'd2);
                    end
                end
                SDCI_DATA: begin
                    // finite only for block mode with nonzero count
                    fin = !s.cmd_word[`SDCI_B_STRM] && s.block_total_count != 16'h0000;
                    if (s.cmd_word[`SDCI_B_WDIR] && fall) begin
                        nxc = s.dcnt + 16'h0001;
                        if (s.dcnt == lbits + 16'h0001) begin
                            nxc = 16'h0000;
                            n.dat_line = 1'b0;
                        end else if (nxc <= lbits && nxc[4:0] == 5'd1) begin
                            // byte order picks the first byte sent
                            word = s.endian_be ? {s.tx_lo, s.tx_hi} :
                                {s.tx_lo[7:0], s.tx_lo[15:8], s.tx_hi[7:0], s.tx_hi[15:8]};
                            n.dbuf = word;
                            n.dat_line = word[31];
                            n.tx_full = 1'b0;
                            tx_ev = 1'b1;
                            // later requests follow each word taken
                            n.dma_req = s.kick_arm;
                        end else if (nxc <= lbits) begin
                            n.dbuf = {s.dbuf[30:0], 1'b0};
                            n.dat_line = s.dbuf[30];
                        end else begin
                            n.dat_line = 1'b1;
                        end
                        n.dcnt = nxc;
                    end else if (!s.cmd_word[`SDCI_B_WDIR] && rise) begin
                        if (s.dcnt == 16'h0000) begin
                            nxc = {15'h0000, !s.dat_sy[1]};
                        end else if (s.dcnt == lbits + 16'h0001) begin
                            nxc = 16'h0000;
                        end else begin
                            nxc = s.dcnt + 16'h0001;
                            rx_ev = s.dcnt[3:0] == 4'h0;
                        end
                        n.dcnt = nxc;
                    end
                    // block end, stop after the last counted block
                    if ((fall && s.cmd_word[`SDCI_B_WDIR] || rise && !s.cmd_word[`SDCI_B_WDIR])
                        && s.dcnt == lbits + 16'h0001) begin
                        n.blk_left = s.blk_left - 16'h0001;
                        if (fin && s.blk_left == 16'h0001) begin
                            n.st = SDCI_IDLE;
                            n.dat_oe = 1'b0;
                            n.dat_line = 1'b1;
                        end
                    end
                end
                default: n.st = SDCI_IDLE;
            endcase
            // Data phase opens with a start bit on writes, a listen on reads
            if (n.st == SDCI_DATA && s.st != SDCI_DATA) begin
                n.dcnt = 16'h0000;
                n.dat_oe = s.cmd_word[`SDCI_B_WDIR];
                n.dat_line = ~s.cmd_word[`SDCI_B_WDIR];
            end
        end

        // Hardware sets win over the clear bit
        if (s.a_wr && s.a_idx == `SDCI_IDX_TXHI) begin
            n.tx_full = 1'b1;
        end
        if (tx_ev) begin
            n.tx_rdy = 1'b1;
        end
        if (rx_ev) begin
            n.rx_rdy = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.block_byte_length <= `SDCI_BLOCK_BYTE_LENGTH_RST;
            s.line <= 1'b1;
            s.dat_line <= 1'b1;
            s.cmd_sy <= 2'b11;
            s.dat_sy <= 2'b11;
        end else begin
            s <= n;
        end
    end

    // Outputs
    assign hreadyout = ~s.rd_ph;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign card_clk = s.card_clk;
    assign cmd_o = s.line;
    assign cmd_oe = s.cmd_oe;
    assign dat_o = s.dat_line;
    assign dat_oe = s.dat_oe;
    assign dma_req = s.dma_req;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence seq_cmd_done;
        s.st == SDCI_CMD && s.div == 8'(HALF_CYC - 1) && s.card_clk && s.cnt == `SDCI_FRAME_LAST;
    endsequence

    sequence seq_enter_cmd;
        s.st != SDCI_CMD ##1 s.st == SDCI_CMD;
    endsequence

    a_cmd_launch: assert property (wr_cmd |=> s.st == SDCI_INIT || s.st == SDCI_CMD)
        else $error("command write did not launch");
    a_cmd_readback: assert property (s.st != SDCI_IDLE && !wr_cmd |=> $stable(s.cmd_word))
        else $error("command word changed during command");
    a_ready_clear: assert property (wr_cmd && hwdata[15] && !tx_ev && !rx_ev |=> !s.tx_rdy && !s.rx_rdy)
        else $error("ready flags not cleared");
    a_init_count: assert property (s.st == SDCI_INIT && n.st == SDCI_CMD && !launch |-> s.cnt == 8'd79)
        else $error("wrong wake-up clock count");
    a_frame_head: assert property (seq_enter_cmd |-> !s.line && s.shift[45:40] == s.cmd_word[5:0]
        && s.shift[39:8] == {s.arg_hi, s.arg_lo})
        else $error("frame head mismatch");
    a_drive_mode: assert property (s.st == SDCI_CMD |-> s.cmd_oe == (s.cmd_word[7] | ~s.line))
        else $error("command drive mode wrong");
    a_dma_kick: assert property (s.a_wr && s.a_idx == `SDCI_IDX_KICK && hwdata[0] |=> dma_req ##1 !dma_req)
        else $error("kick gave no single request");
    a_cmd_only: assert property (seq_cmd_done ##0 s.cmd_word[13:8] == 6'h00 && !launch |=> s.st == SDCI_IDLE)
        else $error("plain command did not finish");
    a_rsp_length: assert property (s.st == SDCI_RSP && n.st != SDCI_RSP && !launch
        |-> s.cnt == (s.cmd_word[10:9] == 2'b10 ? 8'd135 : 8'd47))
        else $error("response length wrong");
    a_busy_hold: assert property (s.st == SDCI_BUSY && !s.dat_sy[1] && !wr_cmd |=> s.st == SDCI_BUSY)
        else $error("left busy while card busy");
    a_block_end: assert property (s.st == SDCI_DATA && n.st == SDCI_IDLE && !launch
        |-> !s.cmd_word[12] && s.block_total_count != 16'h0000 && s.blk_left == 16'h0001)
        else $error("data phase ended early");
endmodule

// ===== verification/sdci_card_model.sv
`timescale 1ns/1ps
module sdci_card_model (
    // Card link
    input wire logic card_clk,
    input wire logic cmd_level,
    output logic card_oe,
    output logic card_o,
    // Test control and capture
    input wire logic rsp_en,
    input wire logic [47:0] rsp_val,
    output logic [47:0] frame,
    output int n_frames
);
    logic [47:0] sh;
    int k;
    // Capture each host frame; answer on falling edges when asked to
    initial begin
        card_oe = 1'b0;
        card_o = 1'b1;
        frame = 48'h0;
        n_frames = 0;
        forever begin
            @(posedge card_clk);
            if (cmd_level === 1'b0) begin
                sh = 48'h0;
                for (k = 0; k < 47; k++) begin
                    @(posedge card_clk);
                    sh = {sh[46:0], cmd_level};
                end
                frame = {1'b0, sh[46:0]};
                n_frames++;
                if (rsp_en) begin
                    repeat (2) @(negedge card_clk);
                    for (k = 47; k >= 0; k--) begin
                        card_oe = 1'b1;
                        card_o = rsp_val[k];
                        @(negedge card_clk);
                    end
                    // Released line falls back to the pull-up
                    card_oe = 1'b0;
                end
            end
        end
    end
endmodule

// ===== verification/tb_sd_card_command_issue.sv
`timescale 1ns/1ps
`include "sdci_defines.svh"
module tb_sd_card_command_issue;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, card_clk, cmd_o, cmd_oe, dat_o, dat_oe, dma_req;
    logic cmd_level, card_oe, card_o;
    logic rsp_en = 1'b0;
    logic [47:0] rsp_val = 48'h0;
    logic [47:0] frame;
    logic [15:0] v;
    int n_frames;
    int n_errors = 0;
    int n_checks = 0;
    int n_hi = 0;
    int n_dma = 0;
    logic dat_busy = 1'b0;
    logic ck_q = 1'b0;
    logic [9:0] dsh = 10'h000;
    // Rows: index, written value, value read back
    localparam logic [47:0] ROWS [8] = '{
        {`SDCI_IDX_ARGLO, 16'h1234, 16'h1234}, {`SDCI_IDX_ARGHI, 16'habcd, 16'habcd},
        {`SDCI_IDX_TXLO, 16'ha5a5, 16'ha5a5}, {`SDCI_IDX_TXHI, 16'h5a5a, 16'h5a5a},
        {`SDCI_IDX_BLOCK_BYTE_LENGTH, 16'h0fff, 16'h0fff}, {`SDCI_IDX_BLOCK_TOTAL_COUNT, 16'h0003, 16'h0003},
        {`SDCI_IDX_RSP0, 16'hffff, 16'h0000}, {16'h3b60, 16'hffff, 16'h0000}};

    always #2 ref_clk = ~ref_clk;
    // Command line has a pull-up; open drain only ever pulls it low
    assign cmd_level = cmd_oe ? cmd_o : (card_oe ? card_o : 1'b1);
    sdci_top #(.HALF_CYC(8)) uut (
        .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .card_clk(card_clk),
        .cmd_o(cmd_o), .cmd_oe(cmd_oe), .cmd_i(cmd_level), .dat_o(dat_o), .dat_oe(dat_oe),
        .dat_i(dat_oe ? dat_o : ~dat_busy), .dma_req(dma_req));
    sdci_card_model card (
        .card_clk(card_clk), .cmd_level(cmd_level), .card_oe(card_oe), .card_o(card_o),
        .rsp_en(rsp_en), .rsp_val(rsp_val), .frame(frame), .n_frames(n_frames));
    // Count high push-pull drive and DMA pulses; capture data bits at card clock rises
    always @(posedge ref_clk) begin
        if (cmd_oe === 1'b1 && cmd_o === 1'b1) n_hi++;
        if (dma_req === 1'b1) n_dma++;
        if (card_clk === 1'b1 && ck_q === 1'b0 && dat_oe === 1'b1) dsh <= {dsh[8:0], dat_o};
        ck_q <= card_clk;
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One single word transfer; hready sampled at rising edges, signals changed just after them
    task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] wd, output logic [15:0] rv);
        int t;
        t = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {14'h0, idx, 2'b00};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1 && t++ < 100) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {16'h0, wd};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1 && t++ < 100) @(posedge ref_clk);
        rv = hrdata[15:0];
        if (t > 100) n_errors++;
    endtask
    // Poll the active status bit until the command sequence ends
    task automatic wait_idle();
        logic [15:0] s;
        int t;
        s = 16'h8;
        t = 0;
        while (s[3] !== 1'b0 && t++ < 3000) bus(1'b0, `SDCI_IDX_STAT, 16'h0, s);
        chk(48'(s[3]), 48'h0);
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        int i;
        int n;
        int t;
        int h0;
        logic p;
        logic [15:0] x;
        do_reset();
        bus(1'b0, `SDCI_IDX_BLOCK_BYTE_LENGTH, 16'h0, v);
        chk(48'(v), 48'h200);
        $display("test reset_values done");
        for (i = 0; i < 8; i++) begin
            bus(1'b1, ROWS[i][47:32], ROWS[i][31:16], x);
            bus(1'b0, ROWS[i][47:32], 16'h0, v);
            chk(48'(v), 48'(ROWS[i][15:0]));
        end
        $display("test register_rows done");
        rsp_val <= 48'h11deadbeefa5;
        rsp_en <= 1'b1;
        h0 = n_hi;
        bus(1'b1, `SDCI_IDX_CMD, 16'h0251, x);
        // arguments left alone until the command ends
        wait_idle();
        chk(frame[47:8], {2'b01, 6'h11, 32'habcd1234});
        chk(48'(frame[0]), 48'h1);
        chk(48'(n_hi - h0), 48'h0);
        bus(1'b0, `SDCI_IDX_CIDX, 16'h0, v);
        chk(48'(v), 48'h11);
        bus(1'b0, `SDCI_IDX_RSP0, 16'h0, v);
        chk(48'(v), 48'hefa5);
        bus(1'b0, `SDCI_IDX_RSP1, 16'h0, v);
        chk(48'(v), 48'hadbe);
        bus(1'b0, `SDCI_IDX_CMD, 16'h0, v);
        chk(48'(v), 48'h0211);
        $display("test command_response done");
        rsp_en <= 1'b0;
        // One-byte write block, card holding busy first
        bus(1'b1, `SDCI_IDX_BLOCK_BYTE_LENGTH, 16'h0001, x);
        bus(1'b1, `SDCI_IDX_BLOCK_TOTAL_COUNT, 16'h0001, x);
        dat_busy <= 1'b1;
        bus(1'b1, `SDCI_IDX_CMD, 16'h2911, x);
        repeat (1200) @(posedge ref_clk);
        bus(1'b0, `SDCI_IDX_STAT, 16'h0, v);
        chk(48'(v[3]), 48'h1);
        dat_busy <= 1'b0;
        wait_idle();
        chk(48'(dsh), 48'h14b);
        bus(1'b0, `SDCI_IDX_STAT, 16'h0, v);
        chk(48'(v[1]), 48'h1);
        $display("test busy_data done");
        h0 = n_hi;
        bus(1'b1, `SDCI_IDX_CMD, 16'hc091, x);
        n = 0;
        t = 0;
        p = 1'b0;
        // Card clock rises seen before the start bit
        while (!(cmd_oe === 1'b1 && cmd_o === 1'b0) && t++ < 5000) begin
            @(negedge ref_clk);
            if (card_clk === 1'b1 && p === 1'b0) n++;
            p = card_clk;
        end
        chk(48'(n), 48'd80);
        @(posedge ref_clk);
        wait_idle();
        chk(48'(frame[45:40]), 48'h11);
        chk(48'(n_hi > h0), 48'h1);
        bus(1'b0, `SDCI_IDX_STAT, 16'h0, v);
        chk(48'(v[1:0]), 48'h0);
        $display("test init_push_pull done");
        h0 = n_dma;
        bus(1'b1, `SDCI_IDX_KICK, 16'h0001, x);
        repeat (3) @(posedge ref_clk);
        chk(48'(n_dma - h0), 48'h1);
        $display("test dma_kick done");
        do_reset();
        chk({41'h0, cmd_oe, card_clk, dma_req, hresp, dat_oe, cmd_o, hreadyout}, 48'h3);
        bus(1'b0, `SDCI_IDX_BLOCK_BYTE_LENGTH, 16'h0, v);
        chk(48'(v), 48'h200);
        $display("test second_reset done");
        conclude();
    end
    // Cut a hang short; the tests need well under this span
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule
